/* inc/emb_map.svh */
// Reset values and mode codes for the embedded memory block
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH

`define EMB_MODE_DUAL    2'h0
`define EMB_MODE_IOCLK   2'h1
`define EMB_MODE_SINGLE  2'h2
`define EMB_RST_FLAG     1'h0
`define EMB_RST_DATA     'h0
`define EMB_RST_ADDR     'h0

`endif

/* inc/emb_pkg.sv */
// Types shared by the embedded memory block
package emb_pkg;
`include "emb_map.svh"

   typedef enum logic [1:0] {
      EMB_DUAL   = `EMB_MODE_DUAL,
      EMB_IOCLK  = `EMB_MODE_IOCLK,
      EMB_SINGLE = `EMB_MODE_SINGLE
   } emb_mode_e;

endpackage

/* src/emb_memory_block.sv */
// Embedded memory block: registered array with optional output stage
`timescale 1ns/1ps
`include "emb_map.svh"

module emb_memory_block
   import emb_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 7
)(
   input  wire logic              CORE_CLK,
   input  wire logic              NRST,
   input  wire logic              CLR_LOCAL_N,
   input  wire logic              CLR_GLOBAL_N,
   input  wire logic              IN_CLR_N,
   input  wire logic              OUT_CLR_N,
   input  wire logic              IN_CE,
   input  wire logic              OUT_CE,
   input  wire logic [1:0]        MODE,
   input  wire logic              OUT_REG_EN,
   input  wire logic              WR_TICK,
   input  wire logic              RD_TICK,
   input  wire logic              OUT_TICK,
   input  wire logic              WE,
   input  wire logic              FETCH_ENABLE,
   input  wire logic [ADDR_W-1:0] WADDR,
   input  wire logic [ADDR_W-1:0] RADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   output logic      [DATA_W-1:0] RDATA,
   output logic                   RDATA_VALID
);

   localparam int DEPTH = 1 << ADDR_W;

   // ****************************************************
   // Mode decode and load strobes
   // ****************************************************
   // The second clocks arrive as tick inputs synchronous to CORE_CLK
   wire logic     clr_n     = NRST & CLR_LOCAL_N & CLR_GLOBAL_N;
   wire logic     in_rst_n  = clr_n & IN_CLR_N;
   wire logic     out_rst_n = clr_n & OUT_CLR_N;
   wire logic     is_dual   = (MODE == EMB_DUAL);
   wire logic     is_io     = (MODE == EMB_IOCLK);
   // Illegal code 3 falls back to the safe single-port behaviour
   wire logic     is_single = !is_dual && !is_io;
   wire logic     wr_load   = IN_CE & (is_dual ? WR_TICK : 1'b1);
   wire logic     rd_load   = IN_CE & (is_dual ? RD_TICK : 1'b1);
   wire logic     out_load  = OUT_CE & (is_io ? OUT_TICK :
                                        is_dual ? RD_TICK : 1'b1);
   wire logic     rd_req    = FETCH_ENABLE & !(is_single & WE);
   wire logic [ADDR_W-1:0] rd_addr = is_single ? WADDR : RADDR;

   // ****************************************************
   // Input registers
   // ****************************************************
   logic              wr_go_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic              rd_go_reg;
   logic [ADDR_W-1:0] raddr_reg;

   always_ff @(posedge CORE_CLK or negedge in_rst_n) begin
      if (!in_rst_n) begin
         wr_go_reg <= `EMB_RST_FLAG;
         waddr_reg <= ADDR_W'(`EMB_RST_ADDR);
         wdata_reg <= DATA_W'(`EMB_RST_DATA);
      end else begin
         wr_go_reg <= wr_load & WE;
         if (wr_load) begin
            waddr_reg <= WADDR;
            wdata_reg <= WDATA;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge in_rst_n) begin
      if (!in_rst_n) begin
         rd_go_reg <= `EMB_RST_FLAG;
         raddr_reg <= ADDR_W'(`EMB_RST_ADDR);
      end else begin
         rd_go_reg <= rd_load & rd_req;
         if (rd_load) begin
            raddr_reg <= rd_addr;
         end
      end
   end

   // ****************************************************
   // Array
   // ****************************************************
   // Array contents are not cleared; a same-address read returns old data
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] arr_q_reg;
   logic              arr_vld_reg;

   always_ff @(posedge CORE_CLK) begin
      if (wr_go_reg) begin
         mem[waddr_reg] <= wdata_reg;
      end
   end

   always_ff @(posedge CORE_CLK or negedge in_rst_n) begin
      if (!in_rst_n) begin
         arr_q_reg   <= DATA_W'(`EMB_RST_DATA);
         arr_vld_reg <= `EMB_RST_FLAG;
      end else begin
         arr_vld_reg <= rd_go_reg;
         if (rd_go_reg) begin
            arr_q_reg <= mem[raddr_reg];
         end
      end
   end

   // ****************************************************
   // Output registers
   // ****************************************************
   logic [DATA_W-1:0] out_q_reg;
   logic              out_vld_reg;

   always_ff @(posedge CORE_CLK or negedge out_rst_n) begin
      if (!out_rst_n) begin
         out_q_reg   <= DATA_W'(`EMB_RST_DATA);
         out_vld_reg <= `EMB_RST_FLAG;
      end else if (out_load) begin
         out_q_reg   <= arr_q_reg;
         out_vld_reg <= arr_vld_reg;
      end
   end

   // Bypass trades one stage of latency for a longer clock-to-out path
   assign RDATA       = OUT_REG_EN ? out_q_reg : arr_q_reg;
   assign RDATA_VALID = OUT_REG_EN ? out_vld_reg : arr_vld_reg;

   // ****************************************************
   // Assertions
   // ****************************************************
   a_write_capture: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (wr_load && WE) |=> wr_go_reg && waddr_reg == $past(WADDR)
                          && wdata_reg == $past(WDATA))
      else $error("write not captured in input registers");

   a_array_update: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      wr_go_reg |=> mem[$past(waddr_reg)] == $past(wdata_reg))
      else $error("array not written from input registers");

   a_out_pipeline: assert property (
      @(posedge CORE_CLK) disable iff (!out_rst_n)
      (out_load && OUT_REG_EN) ##1 OUT_REG_EN
      |-> RDATA == $past(arr_q_reg))
      else $error("output stage does not delay read data by one");

   a_dual_concurrent: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (is_dual && RD_TICK && WR_TICK && IN_CE && WE && FETCH_ENABLE)
      |=> rd_go_reg && wr_go_reg)
      else $error("dual-port read and write not both accepted");

   a_io_inputs: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (is_io && IN_CE && FETCH_ENABLE && !WR_TICK && !RD_TICK)
      |=> rd_go_reg && raddr_reg == $past(RADDR))
      else $error("input clock does not load read side in io mode");

   a_io_output: assert property (
      @(posedge CORE_CLK) disable iff (!out_rst_n)
      (is_io && !OUT_TICK) |=> $stable(out_q_reg) && $stable(out_vld_reg))
      else $error("output register moved without output clock");

   a_in_enable: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      !IN_CE |=> !wr_go_reg && !rd_go_reg && $stable(waddr_reg))
      else $error("input registers loaded while disabled");

   a_out_clear: assert property (
      @(posedge CORE_CLK) disable iff (!NRST)
      (!OUT_CLR_N && IN_CLR_N) |-> !out_vld_reg && out_q_reg == '0)
      else $error("output clear did not act");

   a_clear_sources: assert property (
      @(posedge CORE_CLK)
      (!CLR_LOCAL_N || !CLR_GLOBAL_N || !NRST)
      |-> !wr_go_reg && !rd_go_reg && !arr_vld_reg && !out_vld_reg)
      else $error("register survived an asynchronous clear");

   a_single_excl: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (is_single && WE) |=> !rd_go_reg)
      else $error("single-port read issued during write");

   a_in_clear: assert property (
      @(posedge CORE_CLK) disable iff (!NRST)
      (!IN_CLR_N && OUT_CLR_N)
      |-> !wr_go_reg && !rd_go_reg && !arr_vld_reg && arr_q_reg == '0)
      else $error("input clear did not act");

   a_out_enable: assert property (
      @(posedge CORE_CLK) disable iff (!out_rst_n)
      !OUT_CE |=> $stable(out_q_reg) && $stable(out_vld_reg))
      else $error("output registers loaded while disabled");

   a_dual_ticks: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (is_dual && !WR_TICK) |=> !wr_go_reg)
      else $error("write accepted without write-port clock");

   a_io_write_load: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (is_io && IN_CE && WE && !WR_TICK)
      |=> wr_go_reg && waddr_reg == $past(WADDR))
      else $error("input clock does not load write side in io mode");

   a_single_addr: assert property (
      @(posedge CORE_CLK) disable iff (!in_rst_n)
      (is_single && IN_CE && FETCH_ENABLE && !WE)
      |=> rd_go_reg && raddr_reg == $past(WADDR))
      else $error("single-port read not taken from shared address");

endmodule

/* verification/emb_user_model.sv */
// Far-side user logic model: issues one-cycle memory requests
`timescale 1ns/1ps
module emb_user_model(
   input  wire logic        clk,
   output logic             we,
   output logic             fe,
   output logic [6:0]       wa,
   output logic [6:0]       ra,
   output logic [15:0]      wd
);
   initial begin
      we = 1'h0;
      fe = 1'h0;
      wa = 7'h0;
      ra = 7'h0;
      wd = 16'h0;
   end
   // ****************************************
   // One access, driven just after an edge
   // ****************************************
   task automatic acc(input logic w, input logic r, input logic [6:0] a,
                      input logic [6:0] b, input logic [15:0] d);
      @(posedge clk);
      #1;
      if (w && r && a == b) b = ~b;
      we = w;
      fe = r;
      wa = a;
      ra = b;
      wd = d;
      @(posedge clk);
      #1;
      we = 1'h0;
      fe = 1'h0;
      // Released data is scrambled so stale words cannot pass
      wd = ~wd;
   endtask
endmodule

/* verification/tb.sv */
// Self-checking testbench for the embedded memory block
`timescale 1ns/1ps
module tb;
   import emb_pkg::*;
   logic        clk;
   logic [4:0]  clr_n;
   logic        in_ce, out_ce, oreg, wtk, rtk, otk, we, fe, rvalid;
   logic [1:0]  mode;
   logic [6:0]  wa, ra;
   logic [15:0] wd, rdata;
   int          err_total, num_checks, n0, n1;
   // Clear bits: 0 device, 1 local, 2 global, 3 output side, 4 input side
   emb_memory_block emb_memory_block_inst(.CORE_CLK(clk), .NRST(clr_n[0]),
      .CLR_LOCAL_N(clr_n[1]), .CLR_GLOBAL_N(clr_n[2]), .OUT_CLR_N(clr_n[3]),
      .IN_CLR_N(clr_n[4]), .IN_CE(in_ce), .OUT_CE(out_ce), .MODE(mode),
      .OUT_REG_EN(oreg), .WR_TICK(wtk), .RD_TICK(rtk), .OUT_TICK(otk),
      .WE(we), .FETCH_ENABLE(fe), .WADDR(wa), .RADDR(ra), .WDATA(wd),
      .RDATA(rdata), .RDATA_VALID(rvalid));
   emb_user_model emb_user_model_inst(.clk(clk), .we(we), .fe(fe), .wa(wa),
      .ra(ra), .wd(wd));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string s, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic r, input logic [6:0] a,
                      input logic [6:0] b, input logic [15:0] d);
      emb_user_model_inst.acc(w, r, a, b, d);
   endtask
   // Bounded wait for valid; 8 means none came
   task automatic wv(output int n);
      n = 0;
      while (rvalid !== 1'h1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic rd(input logic [6:0] a, output int n);
      acc(1'h0, 1'h1, 7'h0, a, 16'h0);
      wv(n);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_io();
      // Port ticks low: io mode must load on the input clock alone
      {wtk, rtk} = 2'h0;
      acc(1'h1, 1'h0, 7'h15, 7'h0, 16'hA5C3);
      acc(1'h1, 1'h0, 7'h16, 7'h0, 16'h3C5A);
      rd(7'h15, n0);
      check("rdata", rdata, 16'hA5C3);
      oreg = 1'h1;
      rd(7'h15, n1);
      check("rdata reg", rdata, 16'hA5C3);
      check("extra stage", 16'(n1 - n0), 16'h1);
      otk = 1'h0;
      rd(7'h16, n0);
      repeat (3) @(posedge clk);
      #1;
      check("held", rdata, 16'hA5C3);
      otk = 1'h1;
      {wtk, rtk} = 2'h3;
   endtask
   task automatic t_ce();
      in_ce = 1'h0;
      acc(1'h1, 1'h0, 7'h15, 7'h0, 16'hFFFF);
      in_ce = 1'h1;
      rd(7'h15, n0);
      check("in enable", rdata, 16'hA5C3);
      out_ce = 1'h0;
      rd(7'h16, n0);
      repeat (2) @(posedge clk);
      #1;
      check("out enable", rdata, 16'hA5C3);
      out_ce = 1'h1;
   endtask
   task automatic t_dual();
      mode = EMB_DUAL;
      oreg = 1'h0;
      acc(1'h1, 1'h1, 7'h20, 7'h15, 16'h0F0F);
      wv(n0);
      check("same period", rdata, 16'hA5C3);
      wtk = 1'h0;
      acc(1'h1, 1'h0, 7'h20, 7'h0, 16'hFFFF);
      wtk = 1'h1;
      rd(7'h20, n0);
      check("write port", rdata, 16'h0F0F);
   endtask
   task automatic t_single();
      mode = EMB_SINGLE;
      acc(1'h1, 1'h1, 7'h30, 7'h31, 16'h5A5A);
      wv(n0);
      check("no fetch", 16'(n0), 16'h8);
      // Read address differs so only the shared write address can hit
      acc(1'h0, 1'h1, 7'h30, 7'h31, 16'h0);
      wv(n0);
      check("shared path", rdata, 16'h5A5A);
      // Unused code 3 must behave as single-port
      mode = 2'h3;
      acc(1'h1, 1'h1, 7'h31, 7'h30, 16'h6B6B);
      wv(n0);
      check("code 3 no fetch", 16'(n0), 16'h8);
   endtask
   task automatic t_clr();
      mode = EMB_IOCLK;
      for (int i = 0; i < 5; i++) begin
         oreg = (i == 3);
         rd(7'h15, n0);
         clr_n[i] = 1'h0;
         @(posedge clk);
         #1;
         check("cleared", rdata, 16'h0);
         check("valid", rvalid, 16'h0);
         clr_n[i] = 1'h1;
      end
   endtask
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   initial begin
      // Off time zero so the clear edge is never missed
      #1;
      {in_ce, out_ce, wtk, rtk, otk, oreg} = 6'h3E;
      clr_n = 5'h1E;
      mode = EMB_IOCLK;
      err_total = 0;
      num_checks = 0;
      repeat (12) @(posedge clk);
      #1;
      clr_n[0] = 1'h1;
      t_io();
      t_ce();
      t_dual();
      t_single();
      t_clr();
      end_of_test();
   end
endmodule
